/* ycs_pkg.sv */
// constants and types of the separator control register bank
// ****************************************
// Operation
// - line pll filter 1 is quick; burst pll filter polarity inverted, 0 is quick.
// - burst extraction gain 0 high; pll loop gain 1 high and quick.
// - killer reference 0000 disables detection; higher codes more sensitive; reset 1010.
// - horizontal slice level is code plus 4 lsb, 4 to 19.
// - vertical slice level is horizontal level plus offset code 0 to 15.
// - burst gate start is 0.25 us per code plus 2.0 us.
// - burst gate width is 0.25 us per code plus 0.5 us.
// - converter clock delay codes 01,10,11; code 00 forbidden; reset 11.
// - converter power-down select set stops unused converters.
// - two bits disable widescreen id nrz and subcarrier amplitude checks.
// - no-image section mode picks ordinary, inter-frame, inter-line or straight through.
// - system power-down mode stops dac, memory, converter per code.
// - power-down keeps all register contents; no reset needed to resume.
// - extended video io enable turns on ten extended io pins.
// - video io float select: outputs low at 0, floating at 1.
// - read 0x00 bits 7:6 fixed version code, bit 5 undefined.
// - read 0x00 bits 4:0 killer, no sync, frame, vertical, horizontal flags.
// - read 0x01 holds eight bit noise level, 00 low to FF high.
// - read 0x02 valid flag plus id bits 3-9; 0x03 bits 10-17.
// - aspect words at 0x04 and 0x05, initial 00, 1111, 00h.
// - read 0x06 bits 7:3 aspect decoder checks, 1 normal, 0 error.
// ****************************************
package ycs_pkg;
	// write sub-addresses
	localparam logic [7:0] WA_TEST_CTRL = 8'h11;
	localparam logic [7:0] WA_PLL_KILLER = 8'h12;
	localparam logic [7:0] WA_SLICE = 8'h13;
	localparam logic [7:0] WA_BURST_GATE = 8'h14;
	localparam logic [7:0] WA_ADC_WIDE = 8'h15;
	localparam logic [7:0] WA_POWER_IO = 8'h16;
	localparam logic [7:0] WA_CLAMP_TEST = 8'h17;
	// read sub-addresses
	localparam logic [7:0] RA_STATUS = 8'h00;
	localparam logic [7:0] RA_NOISE = 8'h01;
	localparam logic [7:0] RA_WIDE_LO = 8'h02;
	localparam logic [7:0] RA_WIDE_HI = 8'h03;
	localparam logic [7:0] RA_ASPECT_01 = 8'h04;
	localparam logic [7:0] RA_ASPECT_2 = 8'h05;
	localparam logic [7:0] RA_ASPECT_CHK = 8'h06;
	// reset values of the write registers
	localparam logic [7:0] RST_TEST_CTRL = 8'h08;
	localparam logic [7:0] RST_PLL_KILLER = 8'hDA;
	localparam logic [7:0] RST_SLICE = 8'hF8;
	localparam logic [7:0] RST_BURST_GATE = 8'h53;
	localparam logic [7:0] RST_ADC_WIDE = 8'hE0;
	localparam logic [7:0] RST_POWER_IO = 8'h00;
	localparam logic [7:0] RST_CLAMP_TEST = 8'h00;
	// initial aspect decoder words
	localparam logic [1:0] RST_ASPECT_W0 = 2'h0;
	localparam logic [3:0] RST_ASPECT_W1 = 4'hF;
	localparam logic [7:0] RST_ASPECT_W2 = 8'h00;
	// version code, value arbitrary
	localparam logic [1:0] PRODUCT_VERSION_CODE = 2'h2;
	// field positions
	localparam int POS_LINE_PLL = 7;
	localparam int POS_BURST_PLL = 6;
	localparam int POS_BURST_GAIN = 5;
	localparam int POS_LOOP_GAIN = 4;
	localparam int POS_ADC_PD = 5;
	localparam int POS_NRZ_OFF = 3;
	localparam int POS_FSC_OFF = 2;
	localparam int POS_EXT_IO = 5;
	localparam int POS_FLOAT = 4;
	localparam int POS_FORCED_SYNC = 6;
	// slice and burst gate arithmetic
	localparam logic [4:0] HSLICE_BASE_LSB = 5'h04;
	localparam int GATE_STEP_NS = 250;
	localparam int GATE_START_BASE_NS = 2000;
	localparam int GATE_WIDTH_BASE_NS = 500;
	localparam int CLK_PERIOD_NS = 10;
	localparam logic [9:0] GATE_STEP_CYC = 10'(GATE_STEP_NS / CLK_PERIOD_NS);
	localparam logic [9:0] GATE_START_BASE_CYC = 10'(GATE_START_BASE_NS / CLK_PERIOD_NS);
	localparam logic [9:0] GATE_WIDTH_BASE_CYC = 10'(GATE_WIDTH_BASE_NS / CLK_PERIOD_NS);
	localparam logic [1:0] ADC_DLY_FORBIDDEN = 2'h0;
	// serial slave states
	typedef enum logic [2:0] {
		YCS_IDLE, YCS_DEVADDR, YCS_ACK_DEV, YCS_SUBADDR, YCS_ACK_SUB, YCS_WDATA, YCS_ACK_W,
		YCS_RDATA
	} ycs_state_t;
endpackage

/* ycs_regs.sv */
// serial-bus register bank of the separator: control out, status in
`timescale 1ns/1ps
module ycs_regs (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_addr_sel,
	input wire logic [4:0] i_detect_flags,
	input wire logic [7:0] i_noise_level,
	input wire logic i_wide_id_valid,
	input wire logic [14:0] i_wide_id_bits,
	input wire logic i_aspect_update,
	input wire logic [1:0] i_aspect_w0,
	input wire logic [3:0] i_aspect_w1,
	input wire logic [7:0] i_aspect_w2,
	input wire logic [4:0] i_aspect_checks,
	input wire logic i_line_sync,
	output logic o_sda_oe_n,
	output logic o_line_pll_quick,
	output logic o_burst_pll_quick,
	output logic o_burst_gain_high,
	output logic o_loop_gain_high,
	output logic o_killer_enable,
	output logic [3:0] o_killer_sens,
	output logic [4:0] o_hslice_lsb,
	output logic [5:0] o_vslice_lsb,
	output logic o_burst_gate,
	output logic [1:0] o_adc_clk_delay,
	output logic o_adc_unused_stop,
	output logic o_nrz_check_en,
	output logic o_fsc_check_en,
	output logic [1:0] o_no_image_mode,
	output logic o_dac_stop,
	output logic o_mem_stop,
	output logic o_adc_stop,
	output logic o_ext_io_en,
	output logic o_io_oe_n,
	output logic o_forced_line_sync,
	output logic [7:0] o_test_ctrl,
	output logic [7:0] o_clamp_test
);
	import ycs_pkg::*;

	// ****************************************
	// state record
	// ****************************************
	typedef struct packed {
		ycs_state_t st;
		logic scl;
		logic sda;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] sub;
		logic rd;
		logic sda_oe_n;
		logic [7:0] r11;
		logic [7:0] r12;
		logic [7:0] r13;
		logic [7:0] r14;
		logic [7:0] r15;
		logic [7:0] r16;
		logic [7:0] r17;
		logic [1:0] aw0;
		logic [3:0] aw1;
		logic [7:0] aw2;
		logic [9:0] gate_cnt;
		logic [9:0] gate_from;
		logic [9:0] gate_to;
		logic gate;
	} ycs_regs_t;

	ycs_regs_t s_q;
	ycs_regs_t s_d;

	// read-space decode, separate from the write space
	function automatic logic [7:0] read_mux(input logic [7:0] sa, input ycs_regs_t s);
		case (sa)
			RA_STATUS: read_mux = {PRODUCT_VERSION_CODE, 1'b0, i_detect_flags};
			RA_NOISE: read_mux = i_noise_level;
			RA_WIDE_LO: read_mux = {i_wide_id_valid, i_wide_id_bits[6:0]};
			RA_WIDE_HI: read_mux = i_wide_id_bits[14:7];
			RA_ASPECT_01: read_mux = {2'h0, s.aw0, s.aw1};
			RA_ASPECT_2: read_mux = s.aw2;
			RA_ASPECT_CHK: read_mux = {i_aspect_checks, 3'h0};
			default: read_mux = 8'h00;
		endcase
	endfunction

	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;
	logic [9:0] gate_start_c;
	logic [9:0] gate_end_c;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		s_d.scl = i_scl;
		s_d.sda = i_sda;
		start_c = s_q.scl && i_scl && s_q.sda && !i_sda;
		stop_c = s_q.scl && i_scl && !s_q.sda && i_sda;
		rise_c = !s_q.scl && i_scl;
		fall_c = s_q.scl && !i_scl;
		// burst gate window in system cycles from the line sync centre
		gate_start_c = GATE_START_BASE_CYC + 10'(GATE_STEP_CYC * {6'h0, s_q.r14[7:4]});
		gate_end_c = gate_start_c + GATE_WIDTH_BASE_CYC
			+ 10'(GATE_STEP_CYC * {6'h0, s_q.r14[3:0]});
		// serial slave, sub-addressed; registers never cleared except by reset
		if (start_c) begin
			s_d.st = YCS_DEVADDR;
			s_d.bitcnt = 4'h0;
			s_d.sda_oe_n = 1'b1;
		end else if (stop_c) begin
			s_d.st = YCS_IDLE;
			s_d.sda_oe_n = 1'b1;
		end else begin
			case (s_q.st)
				YCS_IDLE: begin
					s_d.sda_oe_n = 1'b1;
				end
				YCS_DEVADDR, YCS_SUBADDR, YCS_WDATA: begin
					if (rise_c) begin
						s_d.shreg = {s_q.shreg[6:0], i_sda};
						s_d.bitcnt = s_q.bitcnt + 4'h1;
					end
					if (fall_c && s_q.bitcnt == 4'h8) begin
						s_d.bitcnt = 4'h0;
						if (s_q.st == YCS_DEVADDR) begin
							// own address: 7'b100_101x, x from the select pin; low bit of the byte is read/write
							if (s_q.shreg[7:1] == {6'h25, i_addr_sel}) begin
								s_d.rd = s_q.shreg[0];
								s_d.sda_oe_n = 1'b0;
								s_d.st = YCS_ACK_DEV;
							end else begin
								s_d.st = YCS_IDLE;
							end
						end else if (s_q.st == YCS_SUBADDR) begin
							s_d.sub = s_q.shreg;
							s_d.sda_oe_n = 1'b0;
							s_d.st = YCS_ACK_SUB;
						end else begin
							case (s_q.sub)
								WA_TEST_CTRL: s_d.r11 = s_q.shreg;
								WA_PLL_KILLER: s_d.r12 = s_q.shreg;
								WA_SLICE: s_d.r13 = s_q.shreg;
								WA_BURST_GATE: s_d.r14 = s_q.shreg;
								WA_ADC_WIDE: s_d.r15 = s_q.shreg;
								WA_POWER_IO: s_d.r16 = s_q.shreg;
								WA_CLAMP_TEST: s_d.r17 = s_q.shreg;
								default: s_d.r11 = s_q.r11;
							endcase
							s_d.sub = s_q.sub + 8'h01;
							s_d.sda_oe_n = 1'b0;
							s_d.st = YCS_ACK_W;
						end
					end
				end
				YCS_ACK_DEV: begin
					if (fall_c) begin
						if (s_q.rd) begin
							s_d.shreg = read_mux(s_q.sub, s_q);
							s_d.sda_oe_n = read_mux(s_q.sub, s_q) >> 7 == 8'h01 ? 1'b1 : 1'b0;
							s_d.sub = s_q.sub + 8'h01;
							s_d.bitcnt = 4'h0;
							s_d.st = YCS_RDATA;
						end else begin
							s_d.sda_oe_n = 1'b1;
							s_d.st = YCS_SUBADDR;
						end
					end
				end
				YCS_ACK_SUB, YCS_ACK_W: begin
					if (fall_c) begin
						s_d.sda_oe_n = 1'b1;
						s_d.st = YCS_WDATA;
					end
				end
				YCS_RDATA: begin
					// open drain: release for a one, pull for a zero
					if (fall_c) begin
						s_d.bitcnt = s_q.bitcnt + 4'h1;
						if (s_q.bitcnt == 4'h7) begin
							s_d.sda_oe_n = 1'b1;
						end else if (s_q.bitcnt == 4'h8) begin
							s_d.bitcnt = 4'h0;
							s_d.shreg = read_mux(s_q.sub, s_q);
							s_d.sda_oe_n = read_mux(s_q.sub, s_q) >> 7 == 8'h01 ? 1'b1 : 1'b0;
							s_d.sub = s_q.sub + 8'h01;
						end else begin
							s_d.shreg = {s_q.shreg[6:0], 1'b0};
							s_d.sda_oe_n = s_q.shreg[6];
						end
					end
					// master nack ends the read
					if (rise_c && s_q.bitcnt == 4'h8 && i_sda) begin
						s_d.st = YCS_IDLE;
					end
				end
				default: s_d.st = YCS_IDLE;
			endcase
		end
		// aspect words latched from the decoder
		if (i_aspect_update) begin
			s_d.aw0 = i_aspect_w0;
			s_d.aw1 = i_aspect_w1;
			s_d.aw2 = i_aspect_w2;
		end
		// burst gate counter, restarted at each line sync centre; the window is latched there
		// so that a write in mid-line can neither cut nor stretch the gate already running
		if (i_line_sync) begin
			s_d.gate_cnt = 10'h000;
			s_d.gate_from = gate_start_c;
			s_d.gate_to = gate_end_c;
		end else if (s_q.gate_cnt != 10'h3FF) begin
			s_d.gate_cnt = s_q.gate_cnt + 10'h001;
		end
		s_d.gate = (s_q.gate_cnt >= s_q.gate_from) && (s_q.gate_cnt < s_q.gate_to);
	end

	// ****************************************
	// registers; power-down leaves them untouched
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			s_q <= '0;
			s_q.st <= YCS_IDLE;
			s_q.scl <= 1'b1;
			s_q.sda <= 1'b1;
			s_q.sda_oe_n <= 1'b1;
			s_q.r11 <= RST_TEST_CTRL;
			s_q.r12 <= RST_PLL_KILLER;
			s_q.r13 <= RST_SLICE;
			s_q.r14 <= RST_BURST_GATE;
			s_q.r15 <= RST_ADC_WIDE;
			s_q.r16 <= RST_POWER_IO;
			s_q.r17 <= RST_CLAMP_TEST;
			s_q.aw0 <= RST_ASPECT_W0;
			s_q.aw1 <= RST_ASPECT_W1;
			s_q.aw2 <= RST_ASPECT_W2;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// decoded control outputs, registered
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_line_pll_quick <= 1'b1;
			o_burst_pll_quick <= 1'b0;
			o_burst_gain_high <= 1'b1;
			o_loop_gain_high <= 1'b1;
			o_killer_enable <= 1'b1;
			o_killer_sens <= 4'hA;
			o_hslice_lsb <= 5'h13;
			o_vslice_lsb <= 6'h1B;
			o_burst_gate <= 1'b0;
			o_adc_clk_delay <= 2'h3;
			o_adc_unused_stop <= 1'b1;
			o_nrz_check_en <= 1'b1;
			o_fsc_check_en <= 1'b1;
			o_no_image_mode <= 2'h0;
			o_dac_stop <= 1'b0;
			o_mem_stop <= 1'b0;
			o_adc_stop <= 1'b0;
			o_ext_io_en <= 1'b0;
			o_io_oe_n <= 1'b0;
			o_forced_line_sync <= 1'b0;
			o_test_ctrl <= 8'h08;
			o_clamp_test <= 8'h00;
			o_sda_oe_n <= 1'b1;
		end else begin
			o_line_pll_quick <= s_q.r12[POS_LINE_PLL];
			o_burst_pll_quick <= !s_q.r12[POS_BURST_PLL];
			o_burst_gain_high <= !s_q.r12[POS_BURST_GAIN];
			o_loop_gain_high <= s_q.r12[POS_LOOP_GAIN];
			o_killer_enable <= s_q.r12[3:0] != 4'h0;
			o_killer_sens <= s_q.r12[3:0];
			o_hslice_lsb <= HSLICE_BASE_LSB + {1'b0, s_q.r13[7:4]};
			o_vslice_lsb <= {1'b0, HSLICE_BASE_LSB + {1'b0, s_q.r13[7:4]}}
				+ {2'h0, s_q.r13[3:0]};
			o_burst_gate <= s_q.gate;
			// forbidden delay code is held at the last legal setting
			if (s_q.r15[7:6] != ADC_DLY_FORBIDDEN) begin
				o_adc_clk_delay <= s_q.r15[7:6];
			end
			o_adc_unused_stop <= s_q.r15[POS_ADC_PD];
			o_nrz_check_en <= !s_q.r15[POS_NRZ_OFF];
			o_fsc_check_en <= !s_q.r15[POS_FSC_OFF];
			o_no_image_mode <= s_q.r15[1:0];
			o_dac_stop <= s_q.r16[6];
			o_mem_stop <= s_q.r16[7:6] != 2'h0;
			o_adc_stop <= s_q.r16[7:6] == 2'h3;
			o_ext_io_en <= s_q.r16[POS_EXT_IO];
			o_io_oe_n <= s_q.r16[POS_FLOAT];
			o_forced_line_sync <= s_q.r17[POS_FORCED_SYNC];
			o_test_ctrl <= s_q.r11;
			o_clamp_test <= s_q.r17;
			o_sda_oe_n <= s_q.sda_oe_n;
		end
	end
endmodule // ycs_regs

/* ycs_regs_assertions.sv */
// assertion checker on the separator register bank ports
`timescale 1ns/1ps
module ycs_regs_chk (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_line_sync,
	input wire logic o_sda_oe_n,
	input wire logic o_killer_enable,
	input wire logic [3:0] o_killer_sens,
	input wire logic [4:0] o_hslice_lsb,
	input wire logic [5:0] o_vslice_lsb,
	input wire logic o_burst_gate,
	input wire logic [1:0] o_adc_clk_delay,
	input wire logic o_dac_stop,
	input wire logic o_mem_stop,
	input wire logic o_adc_stop
);
	int unsigned len_q;
	int unsigned since_q;
	default clocking dcb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	// ***
	// gate counters
	// ***
	// reset clears the distance count together with the line counter it mirrors
	always_ff @(posedge i_clk) begin
		len_q <= o_burst_gate ? len_q + 1 : 0;
		since_q <= (i_line_sync || !i_nrst) ? 0 : since_q + 1;
	end
	// ***
	// properties
	// ***
	sequence s_scl_low2; !i_scl ##1 !i_scl; endsequence
	property p_sda_low; !$stable(o_sda_oe_n) |-> s_scl_low2; endproperty
	a_sda_low: assert property (p_sda_low) else $error("sda moved with scl high");
	property p_rst; $rose(i_nrst) |-> o_killer_sens == 4'hA && o_hslice_lsb == 5'h13
		&& o_vslice_lsb == 6'h1B && o_adc_clk_delay == 2'h3 && o_sda_oe_n; endproperty
	a_rst: assert property (p_rst) else $error("bad reset decode");
	property p_hsl; o_hslice_lsb >= 5'h04 && o_hslice_lsb <= 5'h13; endproperty
	a_hsl: assert property (p_hsl) else $error("line slice out of range");
	property p_vsl; o_vslice_lsb >= 6'(o_hslice_lsb) && o_vslice_lsb <= 6'(o_hslice_lsb) + 6'h0F;
	endproperty
	a_vsl: assert property (p_vsl) else $error("vertical slice offset wrong");
	property p_kil; o_killer_enable == (o_killer_sens != 4'h0); endproperty
	a_kil: assert property (p_kil) else $error("killer enable wrong");
	property p_dly; o_adc_clk_delay != 2'h0; endproperty
	a_dly: assert property (p_dly) else $error("forbidden delay code");
	property p_pd_adc; o_adc_stop |-> o_dac_stop && o_mem_stop; endproperty
	a_pd_adc: assert property (p_pd_adc) else $error("converter stop alone");
	property p_pd_dac; o_dac_stop |-> o_mem_stop; endproperty
	a_pd_dac: assert property (p_pd_dac) else $error("dac stop without memory stop");
	property p_gw; $fell(o_burst_gate) |-> len_q >= 50 && len_q <= 425; endproperty
	a_gw: assert property (p_gw) else $error("gate width out of range");
	// gate opens two register stages after the counter reaches its start
	property p_gs; $rose(o_burst_gate) |-> since_q >= 202 && since_q <= 577; endproperty
	a_gs: assert property (p_gs) else $error("gate start out of range");
	property p_hold; i_scl && $past(i_scl) |-> $stable({o_killer_sens, o_hslice_lsb,
		o_vslice_lsb, o_adc_clk_delay, o_adc_stop}); endproperty
	a_hold: assert property (p_hold) else $error("control moved off a byte");
endmodule // ycs_regs_chk
bind ycs_regs ycs_regs_chk i_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
	.i_line_sync(i_line_sync), .o_sda_oe_n(o_sda_oe_n), .o_killer_enable(o_killer_enable),
	.o_killer_sens(o_killer_sens), .o_hslice_lsb(o_hslice_lsb), .o_vslice_lsb(o_vslice_lsb),
	.o_burst_gate(o_burst_gate), .o_adc_clk_delay(o_adc_clk_delay), .o_dac_stop(o_dac_stop),
	.o_mem_stop(o_mem_stop), .o_adc_stop(o_adc_stop));

/* ycs_host.sv */
// serial bus master standing in for the host controller
`timescale 1ns/1ps
module ycs_host (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	int hp = 8; // half bit in clocks; bench makes it short or long
	initial {o_scl, o_sda} = 2'b11;
	// wait half a bit, then step just past the edge
	task automatic tick();
		repeat (hp) @(posedge i_clk);
		#1;
	endtask
	// drive while scl low, sample the wire at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		tick();
		o_scl = 1'b1;
		tick();
		r = i_sda;
		o_scl = 1'b0;
	endtask
	// start is (1,0), stop is (0,1): sda moves while scl is high
	task automatic cond(input logic a, input logic b);
		o_sda = a;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda = b;
		tick();
		o_scl = b;
	endtask
	// one byte msb first plus the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, r);
	endtask
	// write by sub-address, or set it and read one byte after a restart
	task automatic acc(input logic [7:0] dev, sub, d, input logic rd, output logic [7:0] q,
		output logic nak);
		logic [3:0] r = 4'h0;
		cond(1'b1, 1'b0);
		xfer(dev, 1'b1, q, r[0]);
		xfer(sub, 1'b1, q, r[1]);
		if (rd) begin
			cond(1'b1, 1'b0);
			xfer(dev | 8'h01, 1'b1, q, r[2]);
		end
		xfer(rd ? 8'hFF : d, 1'b1, q, r[3]);
		cond(1'b0, 1'b1);
		nak = (|r[2:0]) | (!rd & r[3]);
	endtask
endmodule // ycs_host

/* test_video_yc_separator_control_regs.sv */
// self-checking bench for the separator control register bank
`timescale 1ns/1ps
module test_video_yc_separator_control_regs;
	import ycs_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, sync = 1'b0, upd = 1'b0, wvalid = 1'b0;
	logic [1:0] w0 = 2'h0;
	logic [3:0] w1 = 4'h0;
	logic [4:0] flags = 5'h00, checks = 5'h00;
	logic [7:0] noise = 8'h00, w2 = 8'h00;
	logic [14:0] wbits = 15'h0000;
	logic scl, h_sda, sda_oe_n, lpq, bpq, bgh, lgh, ken, gate, aus, nrz, fsc;
	logic dac, mem, adc, ext, io_oe_n, fls, nak;
	logic [3:0] ksens;
	logic [4:0] hsl;
	logic [5:0] vsl;
	logic [1:0] dly, nim;
	logic [7:0] tctl, ctst, rdat;
	int err_total = 0, total_checks = 0, cyc = 0;
	wire logic sda = h_sda & sda_oe_n; // pull-up: a released line reads high
	ycs_regs i_dut (.i_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .i_addr_sel(1'b0),
		.i_detect_flags(flags), .i_noise_level(noise), .i_wide_id_valid(wvalid),
		.i_wide_id_bits(wbits), .i_aspect_update(upd), .i_aspect_w0(w0), .i_aspect_w1(w1),
		.i_aspect_w2(w2), .i_aspect_checks(checks), .i_line_sync(sync), .o_sda_oe_n(sda_oe_n),
		.o_line_pll_quick(lpq), .o_burst_pll_quick(bpq), .o_burst_gain_high(bgh),
		.o_loop_gain_high(lgh), .o_killer_enable(ken), .o_killer_sens(ksens), .o_hslice_lsb(hsl),
		.o_vslice_lsb(vsl), .o_burst_gate(gate), .o_adc_clk_delay(dly), .o_adc_unused_stop(aus),
		.o_nrz_check_en(nrz), .o_fsc_check_en(fsc), .o_no_image_mode(nim), .o_dac_stop(dac),
		.o_mem_stop(mem), .o_adc_stop(adc), .o_ext_io_en(ext), .o_io_oe_n(io_oe_n),
		.o_forced_line_sync(fls), .o_test_ctrl(tctl), .o_clamp_test(ctst));
	ycs_host i_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(h_sda));
	// 100 MHz clock
	always #5 clk = ~clk;
	// line sync pulse, period longer than the widest gate
	always begin
		repeat (1199) @(posedge clk);
		#1 sync = 1'b1;
		@(posedge clk);
		#1 sync = 1'b0;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 50000) begin
			err_total++;
			wrap_up();
		end
	end
	task automatic chk(input logic [63:0] v, input logic [63:0] e);
		total_checks++;
		if (v !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	// write with device address 0x94 (select pin low), expect all bytes acked
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		i_host.acc(8'h94, sub, d, 1'b0, rdat, nak);
		chk(nak, 1'b0);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rdchk(input logic [7:0] sub, input logic [7:0] e);
		i_host.acc(8'h94, sub, 8'h00, 1'b1, rdat, nak);
		chk({nak, rdat}, {1'b0, e});
	endtask
	task automatic t_reset();
		chk({lpq, bpq, bgh, lgh, ken, ksens}, {4'hB, 1'b1, 4'hA});
		chk({hsl, vsl, dly, aus, nrz, fsc, nim}, {5'h13, 6'h1B, 2'h3, 3'h7, 2'h0});
		chk({dac, mem, adc, ext, io_oe_n, fls, tctl, ctst}, {6'h00, 8'h08, 8'h00});
		rdchk(RA_ASPECT_01, 8'h0F);
		rdchk(RA_ASPECT_2, 8'h00);
		$display("end reset");
	endtask
	task automatic t_ctrl();
		wr(WA_PLL_KILLER, 8'h25);
		chk({lpq, bpq, bgh, lgh, ken, ksens}, {4'h4, 1'b1, 4'h5});
		wr(WA_PLL_KILLER, 8'hD0);
		chk({ken, ksens}, 5'h00);
		wr(WA_SLICE, 8'h0F);
		chk({hsl, vsl}, {5'h04, 6'h13});
		wr(WA_SLICE, 8'hF0);
		chk({hsl, vsl}, {5'h13, 6'h13});
		wr(WA_BURST_GATE, 8'hFF);
		repeat (2500) @(posedge clk);
		#1;
		wr(WA_BURST_GATE, 8'h00);
		repeat (2500) @(posedge clk);
		#1;
		wr(WA_TEST_CTRL, 8'hF7);
		wr(WA_CLAMP_TEST, 8'hB0);
		chk({tctl, ctst, fls}, {8'hF7, 8'hB0, 1'b0});
		$display("end ctrl");
	endtask
	// every no-image mode, legal delay codes only
	task automatic t_adc();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = (i == 0) ? 2'h1 : 2'(i);
			wr(WA_ADC_WIDE, {c, i[0], 1'b0, i[0], ~i[0], 2'(i)});
			chk({dly, aus, nrz, fsc, nim}, {c, i[0], ~i[0], i[0], 2'(i)});
		end
		$display("end adc");
	endtask
	task automatic t_power();
		for (int m = 0; m < 4; m++) begin
			wr(WA_POWER_IO, {2'(m), 1'b1, m[0], 4'h0});
			chk({dac, mem, adc, ext, io_oe_n}, {m[0], m != 0, m == 3, 1'b1, m[0]});
			chk({hsl, ksens}, {5'h13, 4'h0});
		end
		wr(WA_POWER_IO, 8'h00);
		chk({dac, mem, adc, ext, io_oe_n}, 5'h00);
		$display("end power");
	endtask
	task automatic t_read();
		logic [7:0] e [8] = '{{PRODUCT_VERSION_CODE, 1'b0, 5'h15}, 8'hA5, 8'hBC, 8'hB4, 8'h29,
			8'h3C, 8'hB0, 8'h00};
		flags = 5'h15;
		noise = 8'hA5;
		wvalid = 1'b1;
		wbits = 15'h5A3C;
		{w0, w1, w2} = {2'h2, 4'h9, 8'h3C};
		checks = 5'h16;
		upd = 1'b1;
		@(posedge clk);
		#1 upd = 1'b0;
		for (int a = 0; a < 8; a++) rdchk(8'(a), e[a]);
		rdchk(WA_PLL_KILLER, 8'h00);
		$display("end read");
	endtask
	// prompt and slow host, wrong device address, unmapped sub-address
	task automatic t_refuse();
		i_host.hp = 5;
		wr(WA_TEST_CTRL, 8'h5A);
		i_host.hp = 20;
		i_host.acc(8'h96, WA_TEST_CTRL, 8'hFF, 1'b0, rdat, nak);
		chk({nak, tctl}, {1'b1, 8'h5A});
		wr(8'h20, 8'h77);
		chk(tctl, 8'h5A);
		i_host.hp = 8;
		$display("end refuse");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (16) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		t_reset();
		t_ctrl();
		t_adc();
		t_power();
		t_read();
		t_refuse();
		wrap_up();
	end
endmodule // test_video_yc_separator_control_regs
